// ### dsc_gate_pkg.sv
// Shared constants, register map and helpers for the deep-sleep clock gate bank
package dsc_gate_pkg;

  // Bus geometry, unit count and reset synchroniser depth
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned UNIT_N = 8;
  localparam int unsigned SYNC_STAGES = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] RUN_CLOCK_CONFIGURATION_OFS = 12'h060;
  localparam logic [ADDR_W-1:0] RUN_CLOCK_GATE_1_OFS = 12'h104;
  localparam logic [ADDR_W-1:0] SLEEP_CLOCK_GATE_1_OFS = 12'h114;
  localparam logic [ADDR_W-1:0] DEEP_SLEEP_CLOCK_GATE_1_OFS = 12'h124;
  localparam logic [ADDR_W-1:0] FAULT_STATUS_OFS = 12'h200;
  localparam logic [ADDR_W-1:0] FAULT_ENABLE_OFS = 12'h204;
  localparam logic [ADDR_W-1:0] FAULT_CLEAR_OFS = 12'h208;
  localparam logic [ADDR_W-1:0] GATE_STATE_OFS = 12'h20C;

  // Gate bit positions inside each 32-bit gating register
  localparam int unsigned ASYNC_SERIAL_A_GATE_BIT = 0;
  localparam int unsigned ASYNC_SERIAL_B_GATE_BIT = 1;
  localparam int unsigned SYNC_SERIAL_PORT_GATE_BIT = 4;
  localparam int unsigned TWO_WIRE_PORT_GATE_BIT = 12;
  localparam int unsigned GENERAL_TIMER_A_GATE_BIT = 16;
  localparam int unsigned GENERAL_TIMER_B_GATE_BIT = 17;
  localparam int unsigned GENERAL_TIMER_C_GATE_BIT = 18;
  localparam int unsigned COMPARATOR_A_GATE_BIT = 24;

  // Implemented (read/write) bits; all others read zero
  localparam logic [DATA_W-1:0] GATE_IMPL_MASK = 32'h0107_1013;
  localparam logic [DATA_W-1:0] GATE_RST = 32'h0000_0000;

  // Run clock configuration fields
  localparam int unsigned AUTO_CLOCK_GATING_SELECT_BIT = 27;
  localparam logic [DATA_W-1:0] RUN_CFG_IMPL_MASK = 32'h0800_0000;
  localparam logic [DATA_W-1:0] RUN_CFG_RST = 32'h0000_0000;

  // Gate state register fields
  localparam int unsigned STATE_MODE_LSB = 8;
  localparam logic [UNIT_N-1:0] UNIT_RST = 8'h00;

  // Power mode seen by the gate selector
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP = 2'b10
  } power_mode_e;

  // Bus answer sequencing
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_e;

  // Gather the implemented gate bits into one unit-indexed vector
  function automatic logic [UNIT_N-1:0] pack_units(input logic [DATA_W-1:0] word);
    pack_units = {word[COMPARATOR_A_GATE_BIT], word[GENERAL_TIMER_C_GATE_BIT],
                  word[GENERAL_TIMER_B_GATE_BIT], word[GENERAL_TIMER_A_GATE_BIT],
                  word[TWO_WIRE_PORT_GATE_BIT], word[SYNC_SERIAL_PORT_GATE_BIT],
                  word[ASYNC_SERIAL_B_GATE_BIT], word[ASYNC_SERIAL_A_GATE_BIT]};
  endfunction

  // Merge write data under byte strobes, keeping only writable bits
  function automatic logic [DATA_W-1:0] apply_strobe(input logic [DATA_W-1:0] old_v,
                                                      input logic [DATA_W-1:0] wdata,
                                                      input logic [3:0] strb,
                                                      input logic [DATA_W-1:0] mask);
    logic [DATA_W-1:0] merged;
    merged = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merged[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    apply_strobe = merged & mask;
  endfunction

endpackage

// ### dsc_reset_sync.sv
// Reset release synchroniser: asynchronous assert, clocked release
`timescale 1ns/1ps
module dsc_reset_sync
  import dsc_gate_pkg::*;
(
  input wire logic clock_in, // System clock
  input wire logic nrst_in, // Raw active-low reset
  output logic nrst_sync_out // Released two edges after nrst_in rises
);

  logic [SYNC_STAGES-1:0] stage_r;

  // Shift ones in after release; only the last stage is used
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage_r <= '0;
    end else begin
      stage_r <= {stage_r[SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign nrst_sync_out = stage_r[SYNC_STAGES-1];

endmodule

// ### dsc_fault_check.sv
// Flags accesses to units whose clock is currently gated off
`timescale 1ns/1ps
module dsc_fault_check
  import dsc_gate_pkg::*;
#(
  parameter int unsigned UNITS = UNIT_N
) (
  input wire logic clock_in, // System clock
  input wire logic nrst_in, // Synchronised active-low reset
  input wire logic [UNITS-1:0] access_in, // One-cycle access strobe per unit
  input wire logic [UNITS-1:0] gate_en_in, // Effective clock enable per unit
  output logic [UNITS-1:0] fault_out // One-cycle bus fault per unit
);

  logic [UNITS-1:0] fault_r;

  // A gated unit cannot answer, so the access is turned into a fault
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fault_r <= '0;
    end else begin
      fault_r <= access_in & ~gate_en_in;
    end
  end

  assign fault_out = fault_r;

endmodule

// ### dsc_gate_bank.sv
`timescale 1ns/1ps
module dsc_gate_bank
  import dsc_gate_pkg::*;
#(
  parameter int unsigned UNITS = UNIT_N
) (
  input wire logic clock_in, // System clock, 100 MHz
  input wire logic nrst_in, // Active-low asynchronous reset
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB access phase
  input wire logic pwrite_in, // APB direction, high for write
  input wire logic [ADDR_W-1:0] paddr_in, // APB byte address
  input wire logic [DATA_W-1:0] pwdata_in, // APB write data
  input wire logic [3:0] pstrb_in, // APB write byte strobes
  output logic [DATA_W-1:0] prdata_out, // APB read data
  output logic pready_out, // APB ready
  output logic pslverr_out, // APB error for unmapped address
  input wire logic sleep_in, // Power controller requests sleep
  input wire logic deep_sleep_in, // Power controller requests deep-sleep
  input wire logic [UNITS-1:0] unit_access_in, // Access strobe toward each unit
  output logic [UNITS-1:0] unit_clk_en_out, // Clock enable to each unit
  output logic [UNITS-1:0] unit_fault_out, // Bus fault pulse per unit
  output logic [1:0] power_mode_out, // Requested mode, registered with the enables; reported even while automatic gating is off
  output logic irq_out // Level interrupt on enabled fault
);

  // Reset copy used by every flip-flop below
  // The raw reset reaches only the synchroniser, never a flop of its own
  logic nrst_sync;

  // Bus sequencing
  bus_state_e bus_state_r;
  bus_state_e bus_state_nxt;
  logic access_start;
  logic access_done;
  logic wr_done;

  // Register file
  logic [DATA_W-1:0] run_clock_configuration_r;
  logic [DATA_W-1:0] run_clock_gate_1_r;
  logic [DATA_W-1:0] sleep_clock_gate_1_r;
  logic [DATA_W-1:0] deep_sleep_clock_gate_1_r;
  logic [UNITS-1:0] fault_status_r;
  logic [UNITS-1:0] fault_status_nxt;
  logic [UNITS-1:0] fault_enable_r;
  logic [UNITS-1:0] fault_clear;

  // Read path
  logic [DATA_W-1:0] rd_value;
  logic addr_hit;
  logic [DATA_W-1:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // Gate selection
  logic auto_gating;
  power_mode_e mode_req;
  power_mode_e mode_r;
  logic [DATA_W-1:0] gate_word;
  logic [UNITS-1:0] gate_sel;
  logic [UNITS-1:0] gate_en_r;
  logic [UNITS-1:0] fault_pulse;
  logic irq_r;

  // Release the reset through two flops so no flop leaves reset on a raw edge
  dsc_reset_sync u_reset_sync (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .nrst_sync_out(nrst_sync)
  );

  // ---------------------------------------------------------------
  // APB slave: one wait cycle, then ready with registered data
  // ---------------------------------------------------------------

  // Answer is registered so that all bus outputs come from flops
  assign access_start = psel_in && penable_in && (bus_state_r == BUS_IDLE);
  assign access_done = psel_in && penable_in && (bus_state_r == BUS_ANSWER);
  assign wr_done = access_done && pwrite_in && addr_hit;

  // Next bus state
  // Exactly one wait cycle; an access phase held past ready starts a new answer
  always_comb begin
    bus_state_nxt = bus_state_r;
    unique case (bus_state_r)
      BUS_IDLE: begin
        if (access_start) begin
          bus_state_nxt = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        bus_state_nxt = BUS_IDLE;
      end
    endcase
  end

  // Bus state register
  always_ff @(posedge clock_in or negedge nrst_sync) begin
    if (!nrst_sync) begin
      bus_state_r <= BUS_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  // Address decode and read multiplexer
  // Unmapped addresses answer with an error instead of silently reading zero
  always_comb begin
    rd_value = '0;
    addr_hit = 1'b1;
    unique case (paddr_in)
      RUN_CLOCK_CONFIGURATION_OFS: begin
        rd_value = run_clock_configuration_r;
      end
      RUN_CLOCK_GATE_1_OFS: begin
        rd_value = run_clock_gate_1_r;
      end
      SLEEP_CLOCK_GATE_1_OFS: begin
        rd_value = sleep_clock_gate_1_r;
      end
      DEEP_SLEEP_CLOCK_GATE_1_OFS: begin
        rd_value = deep_sleep_clock_gate_1_r & GATE_IMPL_MASK;
      end
      FAULT_STATUS_OFS: begin
        rd_value = {{(DATA_W-UNITS){1'b0}}, fault_status_r};
      end
      FAULT_ENABLE_OFS: begin
        rd_value = {{(DATA_W-UNITS){1'b0}}, fault_enable_r};
      end
      FAULT_CLEAR_OFS: begin
        rd_value = '0; // Write-only, reads zero
      end
      GATE_STATE_OFS: begin
        // Placed by field position so a smaller unit count still lines up
        rd_value[UNITS-1:0] = gate_en_r;
        rd_value[STATE_MODE_LSB +: 2] = mode_r;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Capture the answer one cycle into the access phase
  // Read data is zero outside the answer cycle so a stale word never lingers
  always_ff @(posedge clock_in or negedge nrst_sync) begin
    if (!nrst_sync) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= access_start;
      pslverr_r <= access_start && !addr_hit;
      if (access_start && !pwrite_in) begin
        prdata_r <= rd_value;
      end else if (!access_start) begin
        prdata_r <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Gating registers: the three gate words share one layout, reserved bits forced low
  // ---------------------------------------------------------------

  // Run clock configuration holds the automatic gating select
  // Only the select bit is writable; every other bit reads zero
  always_ff @(posedge clock_in or negedge nrst_sync) begin
    if (!nrst_sync) begin
      run_clock_configuration_r <= RUN_CFG_RST;
    end else if (wr_done && paddr_in == RUN_CLOCK_CONFIGURATION_OFS) begin
      run_clock_configuration_r <= apply_strobe(run_clock_configuration_r, pwdata_in,
                                                pstrb_in, RUN_CFG_IMPL_MASK);
    end
  end

  // Run-mode gates
  // Also covers both sleep modes while automatic gating is off
  always_ff @(posedge clock_in or negedge nrst_sync) begin
    if (!nrst_sync) begin
      run_clock_gate_1_r <= GATE_RST;
    end else if (wr_done && paddr_in == RUN_CLOCK_GATE_1_OFS) begin
      run_clock_gate_1_r <= apply_strobe(run_clock_gate_1_r, pwdata_in,
                                         pstrb_in, GATE_IMPL_MASK);
    end
  end

  // Sleep-mode gates
  // Same mask as the other two so all three share one layout
  always_ff @(posedge clock_in or negedge nrst_sync) begin
    if (!nrst_sync) begin
      sleep_clock_gate_1_r <= GATE_RST;
    end else if (wr_done && paddr_in == SLEEP_CLOCK_GATE_1_OFS) begin
      sleep_clock_gate_1_r <= apply_strobe(sleep_clock_gate_1_r, pwdata_in,
                                           pstrb_in, GATE_IMPL_MASK);
    end
  end

  // Deep-sleep gates; everything unclocked after reset
  always_ff @(posedge clock_in or negedge nrst_sync) begin
    if (!nrst_sync) begin
      deep_sleep_clock_gate_1_r <= GATE_RST;
    end else if (wr_done && paddr_in == DEEP_SLEEP_CLOCK_GATE_1_OFS) begin
      // Reserved bits cannot be written, so they always read zero
      deep_sleep_clock_gate_1_r <= apply_strobe(deep_sleep_clock_gate_1_r, pwdata_in,
                                                pstrb_in, GATE_IMPL_MASK);
    end
  end

  // ---------------------------------------------------------------
  // Gate selection by power mode
  // ---------------------------------------------------------------

  // Decides whether the low-power registers are honoured at all
  assign auto_gating = run_clock_configuration_r[AUTO_CLOCK_GATING_SELECT_BIT];

  // Deep-sleep outranks sleep when both requests are high
  // Requests are taken as synchronous; the power controller must not glitch them
  always_comb begin
    if (deep_sleep_in) begin
      mode_req = MODE_DEEP;
    end else if (sleep_in) begin
      mode_req = MODE_SLEEP;
    end else begin
      mode_req = MODE_RUN;
    end
  end

  // Low-power registers only count while automatic gating is selected
  // A mode change swaps whole words, so units never see a mixed enable set
  always_comb begin
    gate_word = run_clock_gate_1_r;
    if (auto_gating) begin
      unique case (mode_req)
        MODE_DEEP: begin
          gate_word = deep_sleep_clock_gate_1_r;
        end
        MODE_SLEEP: begin
          gate_word = sleep_clock_gate_1_r;
        end
        MODE_RUN: begin
          gate_word = run_clock_gate_1_r;
        end
        default: begin
          gate_word = run_clock_gate_1_r;
        end
      endcase
    end
  end

  // One bit per unit: comparator, timers c/b/a, two-wire, sync, async b/a
  assign gate_sel = pack_units(gate_word);

  // Registered enables; a gated unit sees no clock edges and holds still
  // Limitation: a newly enabled unit gets its first edge one cycle after the write
  always_ff @(posedge clock_in or negedge nrst_sync) begin
    if (!nrst_sync) begin
      gate_en_r <= UNIT_RST;
      mode_r <= MODE_RUN;
    end else begin
      gate_en_r <= gate_sel;
      mode_r <= mode_req;
    end
  end

  // ---------------------------------------------------------------
  // Access faults and interrupt
  // ---------------------------------------------------------------

  // Judged against the enables the units actually see this cycle
  // Registering the fault costs a cycle but keeps the pulse free of glitches
  dsc_fault_check #(
    .UNITS(UNITS)
  ) u_fault_check (
    .clock_in(clock_in),
    .nrst_in(nrst_sync),
    .access_in(unit_access_in),
    .gate_en_in(gate_en_r),
    .fault_out(fault_pulse)
  );

  // Write-one-to-clear strobe, only on the completing bus edge
  // Byte strobes are ignored here; a clear always acts on the full word
  assign fault_clear = (wr_done && paddr_in == FAULT_CLEAR_OFS) ? pwdata_in[UNITS-1:0] : '0;

  // A fault in the clearing cycle stays set: set wins over clear
  assign fault_status_nxt = (fault_status_r & ~fault_clear) | fault_pulse;

  // Sticky fault status
  // Reading never clears it; only the clear register does
  always_ff @(posedge clock_in or negedge nrst_sync) begin
    if (!nrst_sync) begin
      fault_status_r <= UNIT_RST;
    end else begin
      fault_status_r <= fault_status_nxt;
    end
  end

  // Fault interrupt enable
  // Only byte lane 0 carries enables, so other lanes are ignored
  always_ff @(posedge clock_in or negedge nrst_sync) begin
    if (!nrst_sync) begin
      fault_enable_r <= UNIT_RST;
    end else if (wr_done && paddr_in == FAULT_ENABLE_OFS && pstrb_in[0]) begin
      fault_enable_r <= pwdata_in[UNITS-1:0];
    end
  end

  // Interrupt level follows status one cycle later
  // Registered so the pin never glitches while status and enable change
  always_ff @(posedge clock_in or negedge nrst_sync) begin
    if (!nrst_sync) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(fault_status_r & fault_enable_r);
    end
  end

  // Outputs, each straight from a flop
  // Flopped ports keep timing at the block edge predictable
  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign unit_clk_en_out = gate_en_r;
  assign unit_fault_out = fault_pulse;
  assign power_mode_out = mode_r;
  assign irq_out = irq_r;

endmodule

// ### dsc_gate_bank_asserts.sv
// Port-level assertions and covers for the deep-sleep clock gate bank
`timescale 1ns/1ps
module dsc_gate_bank_chk
  import dsc_gate_pkg::*;
#(
  parameter int unsigned UNITS = UNIT_N
) (
  input wire logic clock_in, // Clock
  input wire logic nrst_in, // Raw reset
  input wire logic psel_in, // Select
  input wire logic penable_in, // Access phase
  input wire logic pwrite_in, // Direction
  input wire logic [ADDR_W-1:0] paddr_in, // Address
  input wire logic [DATA_W-1:0] pwdata_in, // Write data
  input wire logic [3:0] pstrb_in, // Strobes
  input wire logic [DATA_W-1:0] prdata_out, // Read data
  input wire logic pready_out, // Ready
  input wire logic pslverr_out, // Error
  input wire logic sleep_in, // Sleep request
  input wire logic deep_sleep_in, // Deep request
  input wire logic [UNITS-1:0] unit_access_in, // Unit strobes
  input wire logic [UNITS-1:0] unit_clk_en_out, // Unit enables
  input wire logic [UNITS-1:0] unit_fault_out, // Unit faults
  input wire logic [1:0] power_mode_out, // Requested mode
  input wire logic irq_out // Interrupt
);
  // One clock domain, so clock and disable are stated once
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  // Bus answer comes after exactly one wait cycle and stands one cycle
  a_ready_one_wait: assert property (psel_in && penable_in && !$past(penable_in) |=> pready_out)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  // A unit strobe faults exactly when that unit's clock was off
  a_fault_when_gated: assert property (1'b1 |=>
    unit_fault_out == ($past(unit_access_in) & ~$past(unit_clk_en_out)))
    else $error("fault does not match gated access");
  a_reset_all_off: assert property ($rose(nrst_in) |-> unit_clk_en_out == '0 && !irq_out)
    else $error("unit clock on at reset release");
  a_reserved_reads_zero: assert property (pready_out && !pwrite_in &&
    paddr_in == DEEP_SLEEP_CLOCK_GATE_1_OFS |-> (prdata_out & ~GATE_IMPL_MASK) == '0)
    else $error("reserved gate bit reads nonzero");
  // Deep wins over sleep in the reported mode
  a_mode_follows: assert property (1'b1 |=> power_mode_out ==
    ($past(deep_sleep_in) ? MODE_DEEP : ($past(sleep_in) ? MODE_SLEEP : MODE_RUN)))
    else $error("power mode does not follow request");
  // Interrupt can only rise after a fault or a register write
  a_irq_has_cause: assert property ($rose(irq_out) |->
    $past(|unit_fault_out, 2) || $past(pready_out && pwrite_in, 2))
    else $error("interrupt rose without cause");

  c_fault: cover property (|unit_fault_out);
  c_irq: cover property ($rose(irq_out));
  c_bad_addr: cover property (pslverr_out);
endmodule

bind dsc_gate_bank dsc_gate_bank_chk #(.UNITS(UNITS)) u_chk (.clock_in(clock_in), .nrst_in(nrst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .sleep_in(sleep_in), .deep_sleep_in(deep_sleep_in),
  .unit_access_in(unit_access_in), .unit_clk_en_out(unit_clk_en_out), .unit_fault_out(unit_fault_out),
  .power_mode_out(power_mode_out), .irq_out(irq_out));

// ### tb.sv
// Self-checking testbench for the deep-sleep clock gate bank
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
  import dsc_gate_pkg::*;
  logic clock_in, nrst_in, psel_in, penable_in, pwrite_in, sleep_in, deep_sleep_in;
  logic [ADDR_W-1:0] paddr_in;
  logic [DATA_W-1:0] pwdata_in, prdata_out, rd;
  logic [3:0] pstrb_in;
  logic pready_out, pslverr_out, irq_out, er;
  logic [7:0] unit_access_in, unit_clk_en_out, unit_fault_out;
  logic [1:0] power_mode_out;
  int num_errors = 0;
  int num_checks = 0;
  int bp[8] = '{0, 1, 4, 12, 16, 17, 18, 24};

  dsc_gate_bank #(.UNITS(8)) u_dut (.clock_in(clock_in), .nrst_in(nrst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .sleep_in(sleep_in), .deep_sleep_in(deep_sleep_in), .unit_access_in(unit_access_in),
    .unit_clk_en_out(unit_clk_en_out), .unit_fault_out(unit_fault_out),
    .power_mode_out(power_mode_out), .irq_out(irq_out));

  // 100 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic close_out;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One APB transfer; the request stands until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      close_out();
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  // Mode inputs change at an edge; enables settle within a few cycles
  task automatic mode(input logic s, input logic d);
    @(posedge clock_in);
    sleep_in <= s;
    deep_sleep_in <= d;
    wait_cyc(3);
  endtask

  // One-cycle strobe toward units; fault is looked at in the following cycle
  task automatic touch(input logic [7:0] v);
    @(posedge clock_in);
    unit_access_in <= v;
    @(posedge clock_in);
    unit_access_in <= 8'h00;
    #1;
  endtask

  task automatic s_reset;
    apb(1'b0, DEEP_SLEEP_CLOCK_GATE_1_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, SLEEP_CLOCK_GATE_1_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    `CHK(unit_clk_en_out, 8'h00)
  endtask

  // Each bit alone, through the run register while in run mode
  task automatic s_map;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, RUN_CLOCK_GATE_1_OFS, 32'h0000_0001 << bp[i]);
      wait_cyc(3);
      `CHK(unit_clk_en_out, 8'h01 << i)
    end
    apb(1'b1, DEEP_SLEEP_CLOCK_GATE_1_OFS, 32'hFFFF_FFFF);
    apb(1'b0, DEEP_SLEEP_CLOCK_GATE_1_OFS, 32'h0000_0000);
    `CHK(rd, GATE_IMPL_MASK)
    // Lane 2 alone: the timer gates clear while the other lanes keep their bits
    pstrb_in <= 4'b0100;
    apb(1'b1, DEEP_SLEEP_CLOCK_GATE_1_OFS, 32'h0000_0000);
    pstrb_in <= 4'hF;
    apb(1'b0, DEEP_SLEEP_CLOCK_GATE_1_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0100_1013)
  endtask

  task automatic s_modes;
    apb(1'b1, RUN_CLOCK_GATE_1_OFS, 32'h0000_0013);
    apb(1'b1, SLEEP_CLOCK_GATE_1_OFS, 32'h0000_1000);
    apb(1'b1, DEEP_SLEEP_CLOCK_GATE_1_OFS, 32'h0107_0000);
    mode(1'b0, 1'b1);
    `CHK(unit_clk_en_out, 8'h07)
    `CHK(power_mode_out, MODE_DEEP)
    apb(1'b1, RUN_CLOCK_CONFIGURATION_OFS, 32'h0800_0000);
    wait_cyc(3);
    `CHK(unit_clk_en_out, 8'hF0)
    apb(1'b0, RUN_CLOCK_CONFIGURATION_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0800_0000)
    apb(1'b0, GATE_STATE_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0000_02F0)
    mode(1'b1, 1'b1);
    `CHK(unit_clk_en_out, 8'hF0)
    `CHK(power_mode_out, MODE_DEEP)
    mode(1'b1, 1'b0);
    `CHK(unit_clk_en_out, 8'h08)
    `CHK(power_mode_out, MODE_SLEEP)
    mode(1'b0, 1'b0);
    `CHK(unit_clk_en_out, 8'h07)
    `CHK(power_mode_out, MODE_RUN)
  endtask

  // Gated unit faults, clocked unit does not; an enabled fault raises the interrupt
  task automatic s_fault;
    mode(1'b0, 1'b1);
    touch(8'h01);
    `CHK(unit_fault_out, 8'h01)
    touch(8'h10);
    `CHK(unit_fault_out, 8'h00)
    wait_cyc(3);
    `CHK(irq_out, 1'b0)
    apb(1'b0, FAULT_STATUS_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    apb(1'b1, FAULT_ENABLE_OFS, 32'h0000_0001);
    wait_cyc(3);
    `CHK(irq_out, 1'b1)
    apb(1'b1, FAULT_CLEAR_OFS, 32'h0000_0001);
    wait_cyc(3);
    `CHK(irq_out, 1'b0)
    mode(1'b0, 1'b0);
  endtask

  task automatic s_unmapped;
    apb(1'b0, 12'h300, 32'h0000_0000);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, 12'h300, 32'hFFFF_FFFF);
    `CHK(er, 1'b1)
  endtask

  initial begin
    nrst_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = '0;
    pwdata_in = '0;
    pstrb_in = 4'hF;
    sleep_in = 1'b0;
    deep_sleep_in = 1'b0;
    unit_access_in = 8'h00;
    repeat (3) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    s_reset();
    s_map();
    s_modes();
    s_fault();
    s_unmapped();
    close_out();
  end
endmodule
